// [common/dmactr_map.svh]
// register offsets, field positions, reset values and bus codes of the transfer counter block
`ifndef DMACTR_MAP_SVH
`define DMACTR_MAP_SVH

`define DMACTR_OFS_SRC_LEN 12'h000
`define DMACTR_OFS_DST_LEN 12'h004
`define DMACTR_OFS_SRC_PROG 12'h008
`define DMACTR_OFS_DST_PROG 12'h00c
`define DMACTR_OFS_CELL_LEN 12'h010
`define DMACTR_OFS_CELL_PROG 12'h014
`define DMACTR_OFS_MATCH 12'h018
`define DMACTR_OFS_CTRL 12'h01c
`define DMACTR_OFS_STATUS 12'h020
`define DMACTR_OFS_MASK 12'h024

`define DMACTR_LEN_W 16
`define DMACTR_PAT_W 8
`define DMACTR_FLAG_W 6
`define DMACTR_ZERO16 16'h0000
`define DMACTR_ZERO8 8'h00
`define DMACTR_ZERO6 6'h00
`define DMACTR_FULL_LEN 17'h10000

`define DMACTR_CTRL_ON 0
`define DMACTR_CTRL_MATCH 1
`define DMACTR_CTRL_ABORT 2

`define DMACTR_F_BLOCK 0
`define DMACTR_F_CELL 1
`define DMACTR_F_SRC_DONE 2
`define DMACTR_F_SRC_HALF 3
`define DMACTR_F_DST_DONE 4
`define DMACTR_F_DST_HALF 5

`define DMACTR_HTRANS_NONSEQ 2'b10
`define DMACTR_ADDR_W 12

`endif

// [common/dmactr_pkg.sv]
// shared types of the transfer counter block
package dmactr_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_MOVE
  } dmactr_state_e;
  typedef logic [15:0] dmactr_len_t;
endpackage : dmactr_pkg

// [rtl/dmactr_ahb_slave.sv]
// ahb-lite slave front end: captures the address phase and yields one-cycle read/write strobes
`timescale 1ns/1ps
`include "dmactr_map.svh"
module dmactr_ahb_slave (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // register side
  output logic wrStrobe,
  output logic rdStrobe,
  output logic [`DMACTR_ADDR_W-1:0] regAddr
);
  // ---------------------------------------------
  // address phase capture
  // ---------------------------------------------
  logic next_wrStrobe;
  logic next_rdStrobe;
  logic [`DMACTR_ADDR_W-1:0] next_regAddr;
  logic take;

  // a transfer is taken only when the bus is ready, this slave is selected and htrans is NONSEQ
  always_comb begin
    take = hsel && hready && (htrans == `DMACTR_HTRANS_NONSEQ);
    next_wrStrobe = take && hwrite;
    next_rdStrobe = take && !hwrite;
    next_regAddr = take ? haddr[`DMACTR_ADDR_W-1:0] : regAddr;
  end

  // strobes mark the data phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      regAddr <= '0;
    end else begin
      wrStrobe <= next_wrStrobe;
      rdStrobe <= next_rdStrobe;
      regAddr <= next_regAddr;
    end
  end
endmodule : dmactr_ahb_slave

// [rtl/dmactr_flag_reg.sv]
// sticky event flags with write-one-to-clear and a mask gating one interrupt line
`timescale 1ns/1ps
`include "dmactr_map.svh"
module dmactr_flag_reg #(
  parameter int W = `DMACTR_FLAG_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // events and software clears
  input wire logic [W-1:0] evtSet,
  input wire logic [W-1:0] clrOnes,
  input wire logic [W-1:0] mask,
  // state
  output logic [W-1:0] flags,
  output logic irq
);
  logic [W-1:0] next_flags;
  logic next_irq;

  // set wins over a clear in the same cycle so no event is lost
  always_comb begin
    next_flags = (flags & ~clrOnes) | evtSet;
    next_irq = |(next_flags & mask);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= '0;
      irq <= 1'b0;
    end else begin
      flags <= next_flags;
      irq <= next_irq;
    end
  end
endmodule : dmactr_flag_reg

// [rtl/dmactr_channel.sv]
// one dma channel's length, progress and pattern-match logic behind an ahb-lite register port
`timescale 1ns/1ps
`include "dmactr_map.svh"
// Function
// RULE1: the source length is a 16-bit field where N means N bytes and zero means 65,536 bytes.
// RULE2: the destination length uses the same coding, zero meaning 65,536 bytes.
// RULE3: the cell length is 16 bits giving bytes per trigger event, zero meaning 65,536 bytes.
// RULE4: the source progress pointer is a read-only 16-bit index of the current source byte.
// RULE5: the destination progress pointer is a read-only 16-bit index of the current destination byte.
// RULE6: the cell progress pointer is a read-only count of bytes moved since the last trigger event.
// RULE7: with pattern operation active, a match clears the source and cell progress pointers.
// RULE8: software loads the 8-bit match value, compared only in pattern operation and ignored otherwise.
// RULE9: unused upper bits read as zero and all fields reset to zero.
// RULE10: block done rises when the larger of the two lengths has moved, or on a pattern match.
// RULE11: cell done rises once the cell length has moved for one event.
// RULE12: source and destination done and half flags rise when a pointer equals its length or half of it.
// RULE13: with the match abort option set, a match aborts the transfer and clears the channel enable.
// RULE14: pointers advance by the bytes moved per bus transaction and return to zero at block end.
// RULE15: software changes lengths and the match value only while the channel is off.
module dmactr_channel #(
  parameter int LW = `DMACTR_LEN_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite register port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // transfer engine side
  input wire logic cellTrigger,
  input wire logic byteMoved,
  input wire logic [7:0] byteData,
  output logic channelOn,
  output logic moveReq,
  // interrupt
  output logic irq
);
  // ---------------------------------------------
  // bus front end
  // ---------------------------------------------
  logic wrStrobe;
  logic rdTake;
  logic [`DMACTR_ADDR_W-1:0] regAddr;
  logic [`DMACTR_ADDR_W-1:0] rdAddr;

  dmactr_ahb_slave u_slave (
    .clk(clk),
    .sys_rst(sys_rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wrStrobe(wrStrobe),
    .rdStrobe(),
    .regAddr(regAddr)
  );

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [LW-1:0] srcLength, dstLength, cellLength;
  logic [LW-1:0] srcProgress, dstProgress, cellProgress;
  logic [`DMACTR_PAT_W-1:0] matchValue;
  logic matchEnable, matchAbortEnable;
  logic [`DMACTR_FLAG_W-1:0] flagMask;
  dmactr_pkg::dmactr_state_e state;

  logic [LW-1:0] next_srcLength, next_dstLength, next_cellLength;
  logic [LW-1:0] next_srcProgress, next_dstProgress, next_cellProgress;
  logic [`DMACTR_PAT_W-1:0] next_matchValue;
  logic next_channelOn, next_matchEnable, next_matchAbortEnable, next_moveReq;
  logic [`DMACTR_FLAG_W-1:0] next_flagMask;
  dmactr_pkg::dmactr_state_e next_state;

  logic [`DMACTR_FLAG_W-1:0] evtSet, clrOnes, flags;
  logic [31:0] next_hrdata;

  // expands the zero-means-full coding into a 17-bit byte count
  function automatic logic [LW:0] fullCount(input logic [LW-1:0] len);
    fullCount = (len == '0) ? `DMACTR_FULL_LEN : {1'b0, len}; // RULE1 RULE2 RULE3
  endfunction : fullCount

  // register address match, used by the write decode; reads decode rdAddr with a case
  function automatic logic hit(input logic [`DMACTR_ADDR_W-1:0] a, input logic [`DMACTR_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ---------------------------------------------
  // transfer counting
  // ---------------------------------------------
  logic [LW:0] srcCount, dstCount, cellCount, blockCount, blockLead;
  logic [LW:0] srcNext, dstNext, cellNext;
  logic patternHit, blockEnd, cellEnd;

  // one byte per bus transaction; 17-bit arithmetic keeps the 65,536 case exact
  always_comb begin
    srcCount = fullCount(srcLength);
    dstCount = fullCount(dstLength);
    cellCount = fullCount(cellLength);
    blockCount = (srcCount > dstCount) ? srcCount : dstCount; // RULE10
    srcNext = {1'b0, srcProgress} + 17'h00001; // RULE14
    dstNext = {1'b0, dstProgress} + 17'h00001;
    cellNext = {1'b0, cellProgress} + 17'h00001;
    patternHit = byteMoved && (state == dmactr_pkg::ST_MOVE) && matchEnable
                 && (byteData == matchValue); // RULE8
    // the longer side never wraps inside a block, so its pointer alone measures block progress
    blockLead = (srcCount >= dstCount) ? srcNext : dstNext; // RULE10
    blockEnd = byteMoved && (state == dmactr_pkg::ST_MOVE)
               && ((blockLead >= blockCount) || patternHit);
    cellEnd = byteMoved && (state == dmactr_pkg::ST_MOVE) && (cellNext == cellCount); // RULE11
  end

  // channel sequencing, pointer updates and register writes
  always_comb begin
    next_state = state;
    next_channelOn = channelOn;
    next_srcProgress = srcProgress;
    next_dstProgress = dstProgress;
    next_cellProgress = cellProgress;
    next_srcLength = srcLength;
    next_dstLength = dstLength;
    next_cellLength = cellLength;
    next_matchValue = matchValue;
    next_matchEnable = matchEnable;
    next_matchAbortEnable = matchAbortEnable;
    next_flagMask = flagMask;
    clrOnes = `DMACTR_ZERO6;
    evtSet = `DMACTR_ZERO6;
    case (state)
      dmactr_pkg::ST_IDLE: begin
        if (channelOn) begin
          next_state = dmactr_pkg::ST_WAIT;
        end
      end
      dmactr_pkg::ST_WAIT: begin
        if (!channelOn) begin
          next_state = dmactr_pkg::ST_IDLE;
        end else if (cellTrigger) begin
          next_state = dmactr_pkg::ST_MOVE;
          next_cellProgress = `DMACTR_ZERO16; // RULE6
        end
      end
      dmactr_pkg::ST_MOVE: begin
        if (byteMoved) begin
          // wrap at the programmed length so the index restarts at byte 0
          next_srcProgress = (srcNext >= srcCount) ? `DMACTR_ZERO16 : srcNext[LW-1:0]; // RULE4
          next_dstProgress = (dstNext >= dstCount) ? `DMACTR_ZERO16 : dstNext[LW-1:0]; // RULE5
          next_cellProgress = cellNext[LW-1:0]; // RULE6
          evtSet[`DMACTR_F_SRC_DONE] = (srcNext == srcCount); // RULE12
          evtSet[`DMACTR_F_SRC_HALF] = (srcNext == {1'b0, srcCount[LW:1]}); // RULE12
          evtSet[`DMACTR_F_DST_DONE] = (dstNext == dstCount); // RULE12
          evtSet[`DMACTR_F_DST_HALF] = (dstNext == {1'b0, dstCount[LW:1]}); // RULE12
          evtSet[`DMACTR_F_CELL] = cellEnd; // RULE11
          evtSet[`DMACTR_F_BLOCK] = blockEnd; // RULE10
          if (blockEnd) begin
            next_srcProgress = `DMACTR_ZERO16; // RULE14 RULE7
            next_dstProgress = `DMACTR_ZERO16;
            next_cellProgress = `DMACTR_ZERO16; // RULE7
            next_state = dmactr_pkg::ST_IDLE;
            next_channelOn = 1'b0;
            if (patternHit && !matchAbortEnable) begin
              next_channelOn = 1'b1; // only the abort option drops the enable on a match
            end
          end else if (cellEnd) begin
            next_state = dmactr_pkg::ST_WAIT;
          end
          if (patternHit && matchAbortEnable) begin
            next_channelOn = 1'b0; // RULE13
          end
        end else if (!channelOn) begin
          next_state = dmactr_pkg::ST_IDLE; // software suspend between bytes
        end
      end
      default: begin
        next_state = dmactr_pkg::ST_IDLE;
      end
    endcase
    if (wrStrobe) begin
      // lengths are expected to change only while the channel is off
      if (hit(regAddr, `DMACTR_OFS_SRC_LEN)) next_srcLength = hwdata[LW-1:0]; // RULE1
      if (hit(regAddr, `DMACTR_OFS_DST_LEN)) next_dstLength = hwdata[LW-1:0]; // RULE2
      if (hit(regAddr, `DMACTR_OFS_CELL_LEN)) next_cellLength = hwdata[LW-1:0]; // RULE3
      if (hit(regAddr, `DMACTR_OFS_MATCH)) next_matchValue = hwdata[`DMACTR_PAT_W-1:0]; // RULE8
      if (hit(regAddr, `DMACTR_OFS_CTRL)) begin
        next_channelOn = hwdata[`DMACTR_CTRL_ON];
        next_matchEnable = hwdata[`DMACTR_CTRL_MATCH];
        next_matchAbortEnable = hwdata[`DMACTR_CTRL_ABORT];
      end
      if (hit(regAddr, `DMACTR_OFS_STATUS)) clrOnes = hwdata[`DMACTR_FLAG_W-1:0];
      if (hit(regAddr, `DMACTR_OFS_MASK)) next_flagMask = hwdata[`DMACTR_FLAG_W-1:0];
    end
    next_moveReq = (next_state == dmactr_pkg::ST_MOVE);
  end

  // ---------------------------------------------
  // read mux; unused upper bits read zero
  // ---------------------------------------------
  // decoded in the address phase so the registered word stands through the whole data phase;
  // a read placed in the cycle right after a write to the same word still sees the old value
  always_comb begin
    rdTake = hsel && hready && (htrans == `DMACTR_HTRANS_NONSEQ) && !hwrite;
    rdAddr = haddr[`DMACTR_ADDR_W-1:0];
    next_hrdata = 32'h00000000; // RULE9
    if (rdTake) begin
      case (rdAddr)
        `DMACTR_OFS_SRC_LEN: next_hrdata[LW-1:0] = srcLength;
        `DMACTR_OFS_DST_LEN: next_hrdata[LW-1:0] = dstLength;
        `DMACTR_OFS_SRC_PROG: next_hrdata[LW-1:0] = srcProgress; // RULE4
        `DMACTR_OFS_DST_PROG: next_hrdata[LW-1:0] = dstProgress; // RULE5
        `DMACTR_OFS_CELL_LEN: next_hrdata[LW-1:0] = cellLength;
        `DMACTR_OFS_CELL_PROG: next_hrdata[LW-1:0] = cellProgress; // RULE6
        `DMACTR_OFS_MATCH: next_hrdata[`DMACTR_PAT_W-1:0] = matchValue;
        `DMACTR_OFS_CTRL: next_hrdata[2:0] = {matchAbortEnable, matchEnable, channelOn};
        `DMACTR_OFS_STATUS: next_hrdata[`DMACTR_FLAG_W-1:0] = flags;
        `DMACTR_OFS_MASK: next_hrdata[`DMACTR_FLAG_W-1:0] = flagMask;
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  // every field clears at reset; the slave is zero-wait so hreadyout stays high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= dmactr_pkg::ST_IDLE;
      channelOn <= 1'b0;
      srcLength <= `DMACTR_ZERO16; // RULE9
      dstLength <= `DMACTR_ZERO16;
      cellLength <= `DMACTR_ZERO16;
      srcProgress <= `DMACTR_ZERO16;
      dstProgress <= `DMACTR_ZERO16;
      cellProgress <= `DMACTR_ZERO16;
      matchValue <= `DMACTR_ZERO8;
      matchEnable <= 1'b0;
      matchAbortEnable <= 1'b0;
      flagMask <= `DMACTR_ZERO6;
      moveReq <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      state <= next_state;
      channelOn <= next_channelOn;
      srcLength <= next_srcLength;
      dstLength <= next_dstLength;
      cellLength <= next_cellLength;
      srcProgress <= next_srcProgress;
      dstProgress <= next_dstProgress;
      cellProgress <= next_cellProgress;
      matchValue <= next_matchValue;
      matchEnable <= next_matchEnable;
      matchAbortEnable <= next_matchAbortEnable;
      flagMask <= next_flagMask;
      moveReq <= next_moveReq;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------
  // event flags and interrupt
  // ---------------------------------------------
  dmactr_flag_reg #(.W(`DMACTR_FLAG_W)) u_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .evtSet(evtSet),
    .clrOnes(clrOnes),
    .mask(flagMask),
    .flags(flags),
    .irq(irq)
  );

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_match_clears_ptrs: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    patternHit |=> (srcProgress == '0) && (cellProgress == '0))
    else $error("pattern match did not clear pointers");
  a_match_abort_off: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    (patternHit && matchAbortEnable && !wrStrobe) |=> !channelOn)
    else $error("match abort left channel on");
  a_block_flag_set: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
    blockEnd |=> flags[`DMACTR_F_BLOCK])
    else $error("block done flag missing");
  a_cell_flag_set: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    cellEnd |=> flags[`DMACTR_F_CELL])
    else $error("cell done flag missing");
  a_src_done_flag: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    (byteMoved && state == dmactr_pkg::ST_MOVE && srcNext == srcCount) |=> flags[`DMACTR_F_SRC_DONE])
    else $error("source done flag missing");
  a_src_ptr_step: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    (byteMoved && state == dmactr_pkg::ST_MOVE && !blockEnd && srcNext < srcCount)
      |=> srcProgress == $past(srcProgress) + 16'h0001)
    else $error("source pointer did not advance by one");
  a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    hrdata[31:LW] == '0)
    else $error("upper read bits not zero");
  a_cell_ptr_trig: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    (state == dmactr_pkg::ST_WAIT && channelOn && cellTrigger) |=> cellProgress == '0)
    else $error("cell pointer not cleared on trigger");
  a_no_match_off: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    (byteMoved && state == dmactr_pkg::ST_MOVE && channelOn && !matchEnable && !wrStrobe
      && blockLead < blockCount) |=> channelOn)
    else $error("match seen outside pattern mode");
endmodule : dmactr_channel

// [tb/dmactr_engine_model.sv]
// behavioural transfer engine that answers the channel's move requests one byte at a time
`timescale 1ns/1ps
module dmactr_engine_model (
  // clock and reset
  input wire logic clk,
  input wire logic sysRst,
  // channel side
  input wire logic channelOn,
  input wire logic moveReq,
  // knobs set by the bench
  input wire logic [2:0] gapCycles,
  input wire logic [15:0] matchAfter,
  input wire logic [7:0] matchByte,
  // byte stream into the channel
  output logic byteMoved,
  output logic [7:0] byteData
);
  logic [2:0] idleCnt;
  logic [15:0] sent;
  // one byte per bus transaction, then at least one idle cycle so a late byte never lands after moveReq falls
  always_ff @(posedge clk or posedge sysRst) begin
    if (sysRst) begin
      byteMoved <= 1'b0;
      byteData <= 8'h00;
      idleCnt <= 3'h0;
      sent <= 16'h0000;
    end else begin
      byteMoved <= 1'b0;
      byteData <= ~byteData; // data is only valid with the strobe, so keep it moving
      if (!channelOn) sent <= 16'h0000;
      if (idleCnt != 3'h0) begin
        idleCnt <= idleCnt - 3'h1;
      end else if (moveReq && !byteMoved) begin
        byteMoved <= 1'b1;
        byteData <= (sent == matchAfter) ? matchByte : ~matchByte;
        sent <= sent + 16'h0001;
        idleCnt <= gapCycles;
      end
    end
  end
endmodule : dmactr_engine_model

// [tb/dmactr_channel_bench.sv]
// self-checking bench for the channel counters, registers and flags
`timescale 1ns/1ps
`include "dmactr_map.svh"
`define CHECK(what, exp, got) begin checksDone++; if ((got) !== (exp)) begin errCount++; \
  $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module dmactr_channel_bench;
  logic clk, sysRst, hsel, hwrite, cellTrigger, hreadyout, hresp, byteMoved, channelOn, moveReq, irq;
  logic [31:0] haddr, hwdata, hrdata, rdVal;
  logic [1:0] htrans;
  logic [2:0] hsize, gapCycles;
  logic [7:0] byteData, matchByte;
  logic [15:0] matchAfter;
  integer seed, errCount, checksDone;
  int s, d, c, k, m, t;
  // device under test, hready fed back from its own hreadyout
  dmactr_channel uut (.clk(clk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cellTrigger(cellTrigger), .byteMoved(byteMoved),
    .byteData(byteData), .channelOn(channelOn), .moveReq(moveReq), .irq(irq));
  dmactr_engine_model engine (.clk(clk), .sysRst(sysRst), .channelOn(channelOn), .moveReq(moveReq),
    .gapCycles(gapCycles), .matchAfter(matchAfter), .matchByte(matchByte), .byteMoved(byteMoved),
    .byteData(byteData));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // bus tasks and expectations
  // ----------------------------------------
  task automatic testDone();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : testDone
  // one single transfer; entered and left right after a rising edge
  // waits for hready as long as it takes; only the watchdog ends a stuck wait
  task automatic ahbXfer(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= `DMACTR_HTRANS_NONSEQ;
    haddr <= {20'h00000, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahbXfer
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahbXfer(a, 1'b1, v, x);
  endtask : wr
  task automatic chkReg(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    ahbXfer(a, 1'b0, 32'h00000000, x);
    `CHECK(nm, exp, x)
    `CHECK("hresp", 1'b0, hresp)
  endtask : chkReg
  // hold the trigger until the cell starts, then wait for it to finish
  task automatic cellOnce();
    cellTrigger <= 1'b1;
    while (moveReq !== 1'b1) @(posedge clk);
    cellTrigger <= 1'b0;
    while (moveReq !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : cellOnce
  // program lengths with the channel off, clear status, then enable with the given mode
  task automatic start(input int ls, input int ld, input int lc, input logic [2:0] mode);
    wr(`DMACTR_OFS_CTRL, 32'h00000000);
    wr(`DMACTR_OFS_SRC_LEN, 32'(ls));
    wr(`DMACTR_OFS_DST_LEN, 32'(ld));
    wr(`DMACTR_OFS_CELL_LEN, 32'(lc));
    wr(`DMACTR_OFS_STATUS, 32'h0000003f);
    wr(`DMACTR_OFS_CTRL, {29'h0, mode});
    repeat (2) @(posedge clk);
  endtask : start
  // flags expected after n bytes; pointers wrap at their own length
  function automatic logic [31:0] expFlags(int ls, int ld, int lc, int n);
    logic [5:0] f;
    f = 6'h00;
    for (int i = 1; i <= n; i++) begin
      if (i % lc == 0) f[`DMACTR_F_CELL] = 1'b1;
      if (i % ls == 0) f[`DMACTR_F_SRC_DONE] = 1'b1;
      if ((i - 1) % ls + 1 == ls / 2) f[`DMACTR_F_SRC_HALF] = 1'b1;
      if (i % ld == 0) f[`DMACTR_F_DST_DONE] = 1'b1;
      if ((i - 1) % ld + 1 == ld / 2) f[`DMACTR_F_DST_HALF] = 1'b1;
    end
    if (n >= ((ls > ld) ? ls : ld)) f[`DMACTR_F_BLOCK] = 1'b1;
    return {26'h0, f};
  endfunction : expFlags
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    seed = 32'h37d4;
    errCount = 0;
    checksDone = 0;
    sysRst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    cellTrigger = 1'b0;
    gapCycles = 3'h1;
    matchAfter = 16'hffff;
    matchByte = 8'h00;
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    // every register and one unmapped word read zero after reset
    for (k = 0; k < 11; k++) chkReg("resetValue", 12'(4 * k), 32'h0);
    // progress pointers and unmapped space ignore writes
    wr(`DMACTR_OFS_SRC_PROG, 32'hffffffff);
    wr(`DMACTR_OFS_DST_PROG, 32'hffffffff);
    wr(`DMACTR_OFS_CELL_PROG, 32'hffffffff);
    wr(12'h028, 32'hffffffff);
    chkReg("srcProgress", `DMACTR_OFS_SRC_PROG, 32'h0);
    chkReg("dstProgress", `DMACTR_OFS_DST_PROG, 32'h0);
    chkReg("cellProgress", `DMACTR_OFS_CELL_PROG, 32'h0);
    chkReg("unmapped", 12'h028, 32'h0);
    // lengths and match value keep their field, upper bits read zero
    for (k = 0; k < 4; k++) begin
      rdVal = $random(seed);
      if (k == 3) rdVal[15:0] = 16'h0000;
      m = (k == 3) ? 0 : k;
      wr((m == 2) ? `DMACTR_OFS_CELL_LEN : 12'(4 * m), rdVal);
      chkReg("length", (m == 2) ? `DMACTR_OFS_CELL_LEN : 12'(4 * m), {16'h0, rdVal[15:0]});
      wr(`DMACTR_OFS_MATCH, rdVal);
      chkReg("matchValue", `DMACTR_OFS_MATCH, {24'h0, rdVal[7:0]});
    end
    // hand case: two cells, source wraps before the longer destination ends
    wr(`DMACTR_OFS_MASK, 32'h0000003f);
    start(4, 6, 3, 3'h1);
    cellOnce();
    chkReg("statusCell", `DMACTR_OFS_STATUS, expFlags(4, 6, 3, 3));
    chkReg("srcMid", `DMACTR_OFS_SRC_PROG, 32'h3);
    chkReg("dstMid", `DMACTR_OFS_DST_PROG, 32'h3);
    cellOnce();
    chkReg("statusBlock", `DMACTR_OFS_STATUS, expFlags(4, 6, 3, 6));
    chkReg("dstEnd", `DMACTR_OFS_DST_PROG, 32'h0);
    `CHECK("channelOn", 1'b0, channelOn)
    `CHECK("irqSet", 1'b1, irq)
    // mask off, then a single bit in, then clear it by writing one
    wr(`DMACTR_OFS_MASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHECK("irqMasked", 1'b0, irq)
    wr(`DMACTR_OFS_MASK, 32'h00000001);
    repeat (2) @(posedge clk);
    `CHECK("irqBlock", 1'b1, irq)
    wr(`DMACTR_OFS_STATUS, 32'h00000001);
    chkReg("statusW1c", `DMACTR_OFS_STATUS, 32'h0000003e);
    `CHECK("irqCleared", 1'b0, irq)
    wr(`DMACTR_OFS_MASK, 32'h0000003f);
    // random blocks, engine prompt or slow
    for (t = 0; t < 5; t++) begin
      rdVal = $random(seed);
      gapCycles <= {1'b0, rdVal[1:0]};
      c = 2 + rdVal[3:2] % 3;
      m = c * (1 + rdVal[5:4] % 3);
      k = 2 + rdVal[11:8] % (m - 1);
      s = rdVal[12] ? m : k;
      d = rdVal[12] ? k : m;
      start(s, d, c, 3'h1);
      for (k = 0; k < 12 && channelOn === 1'b1; k++) cellOnce();
      chkReg("statusRand", `DMACTR_OFS_STATUS, expFlags(s, d, c, m));
      chkReg("srcEnd", `DMACTR_OFS_SRC_PROG, 32'h0);
      chkReg("cellEnd", `DMACTR_OFS_CELL_PROG, 32'h0);
      `CHECK("irqRand", 1'b1, irq)
    end
    // match byte arrives sixth: ignored, ends the block, or ends it and disables the channel
    for (t = 0; t < 3; t++) begin
      rdVal = $random(seed);
      matchByte <= rdVal[7:0];
      matchAfter <= 16'h0005;
      wr(`DMACTR_OFS_MATCH, rdVal);
      m = (t == 0) ? 1 : (t == 1) ? 3 : 7;
      start(8, 8, 8, 3'(m));
      cellOnce();
      chkReg("statusMatch", `DMACTR_OFS_STATUS, (t == 0) ? expFlags(8, 8, 8, 8) : 32'h00000029);
      chkReg("srcMatch", `DMACTR_OFS_SRC_PROG, 32'h0);
      chkReg("cellMatch", `DMACTR_OFS_CELL_PROG, 32'h0);
      `CHECK("channelOnMatch", (t == 1), channelOn)
    end
    wr(`DMACTR_OFS_CTRL, 32'h0);
    testDone();
  end
  // watchdog against a hang anywhere above
  initial begin
    repeat (40000) @(posedge clk);
    errCount++;
    testDone();
  end
endmodule : dmactr_channel_bench
